// ### pkg/ltovr_pkg.sv
// Constants, field layout and carrier types of the lane 0 training override registers.
package ltovr_pkg;
	localparam logic [7:0] LTOVR_IDX_TRAIN_CTRL = 8'hD0;
	localparam logic [7:0] LTOVR_IDX_NEXT_CTRL = 8'hD2;
	localparam logic [7:0] LTOVR_IDX_LP_COEFF = 8'hD5;
	localparam logic [7:0] LTOVR_IDX_LIMIT_OVR = 8'hD6;
	localparam logic [9:0] LTOVR_ADDR_TRAIN_CTRL = {LTOVR_IDX_TRAIN_CTRL, 2'b00};
	localparam logic [9:0] LTOVR_ADDR_NEXT_CTRL = {LTOVR_IDX_NEXT_CTRL, 2'b00};
	localparam logic [9:0] LTOVR_ADDR_LP_COEFF = {LTOVR_IDX_LP_COEFF, 2'b00};
	localparam logic [9:0] LTOVR_ADDR_LIMIT_OVR = {LTOVR_IDX_LIMIT_OVR, 2'b00};
	localparam int LTOVR_TRAIN_EN_BIT = 0;
	localparam int LTOVR_LP_OVR_EN_BIT = 17;
	localparam int LTOVR_NEW_WORD_BIT = 8;
	localparam int LTOVR_COEFF_W = 6;
	localparam int LTOVR_MAX_LSB = 0;
	localparam int LTOVR_MAX_EN_BIT = 5;
	localparam int LTOVR_MIN_LSB = 8;
	localparam int LTOVR_MIN_EN_BIT = 13;
	localparam int LTOVR_POST_LSB = 16;
	localparam int LTOVR_POST_EN_BIT = 22;
	localparam logic LTOVR_TRAIN_EN_RST = 1'b1;
	localparam logic LTOVR_LP_OVR_EN_RST = 1'b0;
	localparam logic [4:0] LTOVR_MAX_RST_SIM = 5'h1C;
	localparam logic [4:0] LTOVR_MIN_RST_SIM = 5'h19;
	localparam logic [5:0] LTOVR_POST_RST_SIM = 6'h06;
	localparam logic LTOVR_EN_RST_SIM = 1'b1;
	localparam logic [4:0] LTOVR_MAIN_RST_HW = 5'h00;
	localparam logic [5:0] LTOVR_POST_RST_HW = 6'h00;
	localparam logic LTOVR_EN_RST_HW = 1'b0;
	localparam logic [1:0] LTOVR_TAP_HOLD = 2'b00;
	localparam logic [1:0] LTOVR_TAP_INC = 2'b01;
	localparam logic [1:0] LTOVR_TAP_DEC = 2'b10;
	localparam logic [1:0] LTOVR_TAP_RSVD = 2'b11;
	localparam logic LTOVR_HRESP_OKAY = 1'b0;

	typedef enum logic [0:0] {
		LTOVR_ST_IDLE = 1'b0,
		LTOVR_ST_WRITE = 1'b1
	} ltovr_state_type;

	typedef struct packed {
		logic [4:0] upper;
		logic [4:0] lower;
		logic [5:0] post;
		logic [4:0] preset;
	} ltovr_limits_type;

	typedef struct packed {
		logic [4:0] max_val;
		logic max_en;
		logic [4:0] min_val;
		logic min_en;
		logic [5:0] post_val;
		logic post_en;
	} ltovr_ovr_type;
endpackage : ltovr_pkg

// ### rtl/ltovr_limit_sel.sv
// Registered selection of the lane 0 TX equaliser limits between configured and override values.
`timescale 1ns/100ps
module ltovr_limit_sel (
	input wire logic hclk,
	input wire logic hresetn,
	input wire ltovr_pkg::ltovr_ovr_type ovr,
	input wire ltovr_pkg::ltovr_limits_type cfg,
	output ltovr_pkg::ltovr_limits_type tx_limits
);
	import ltovr_pkg::*;

	ltovr_limits_type lim_reg;
	ltovr_limits_type lim_next;

	always_comb begin
		lim_next = cfg;
		if (ovr.max_en) begin
			lim_next.upper = ovr.max_val;
			lim_next.preset = ovr.max_val;
		end
		if (ovr.min_en) begin
			lim_next.lower = ovr.min_val;
		end
		if (ovr.post_en) begin
			lim_next.post = ovr.post_val;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lim_reg <= '0;
		end else begin
			lim_reg <= lim_next;
		end
	end

	assign tx_limits = lim_reg;
endmodule : ltovr_limit_sel

// ### rtl/ltovr_regs.sv
// AHB-Lite register slice for lane 0 link training coefficient and limit overrides.
// What this block does
// - Coefficient update bits follow training while enabled, writable once training is disabled.
// - Each 2-bit tap field: 00 hold, 01 increment, 10 decrement, 11 reserved.
// - Max main-tap override replaces the upper limit when enabled; resets 28 or 0.
// - Bit 5 enables the max main-tap override; resets 1 in simulation, else 0.
// - Active max override also replaces preset main tap; program above initial value.
// - Min main-tap override at 12:8, enable bit 13, resets 25 or 0.
// - Post-tap override at 21:16 replaces post-tap limit when enabled; resets 6 or 0.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/100ps
module ltovr_regs #(
	parameter bit SIM_BUILD = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [5:0] lp_coeff_in,
	input wire ltovr_pkg::ltovr_limits_type cfg_limits,
	output ltovr_pkg::ltovr_limits_type tx_limits,
	output logic [5:0] lp_coeff_out,
	output logic [2:0] tap_inc,
	output logic [2:0] tap_dec,
	output logic train_enable,
	output logic lp_coeff_send
);
	import ltovr_pkg::*;

	localparam logic [4:0] MAX_RST = SIM_BUILD ? LTOVR_MAX_RST_SIM
		: LTOVR_MAIN_RST_HW;
	localparam logic [4:0] MIN_RST = SIM_BUILD ? LTOVR_MIN_RST_SIM
		: LTOVR_MAIN_RST_HW;
	localparam logic [5:0] POST_RST = SIM_BUILD ? LTOVR_POST_RST_SIM
		: LTOVR_POST_RST_HW;
	localparam logic EN_RST = SIM_BUILD ? LTOVR_EN_RST_SIM : LTOVR_EN_RST_HW;
	localparam ltovr_ovr_type OVR_RST = '{max_val: MAX_RST, max_en: EN_RST,
		min_val: MIN_RST, min_en: EN_RST, post_val: POST_RST, post_en: EN_RST};

	ltovr_state_type st_reg, st_next;
	logic [9:0] wa_reg, wa_next;
	logic train_en_reg, train_en_next;
	logic lp_ovr_en_reg, lp_ovr_en_next;
	logic [5:0] coeff_reg, coeff_next;
	ltovr_ovr_type ovr_reg, ovr_next;
	logic send_reg, send_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [2:0] inc_reg, inc_next, dec_reg, dec_next;
	logic addr_phase;
	logic wr_ctrl, wr_next_ctrl, wr_coeff, wr_ovr;

	// Bus slave: zero wait states, so read data are built from next values.
	always_comb begin
		addr_phase = hsel && htrans[1] && hready;
		st_next = LTOVR_ST_IDLE;
		wa_next = wa_reg;
		if (addr_phase && hwrite) begin
			st_next = LTOVR_ST_WRITE;
			wa_next = haddr[9:0];
		end
		wr_ctrl = (st_reg == LTOVR_ST_WRITE) && (wa_reg == LTOVR_ADDR_TRAIN_CTRL);
		wr_next_ctrl = (st_reg == LTOVR_ST_WRITE)
			&& (wa_reg == LTOVR_ADDR_NEXT_CTRL);
		wr_coeff = (st_reg == LTOVR_ST_WRITE) && (wa_reg == LTOVR_ADDR_LP_COEFF);
		wr_ovr = (st_reg == LTOVR_ST_WRITE) && (wa_reg == LTOVR_ADDR_LIMIT_OVR);
	end

	// Register contents.
	always_comb begin
		train_en_next = train_en_reg;
		lp_ovr_en_next = lp_ovr_en_reg;
		coeff_next = coeff_reg;
		ovr_next = ovr_reg;
		if (wr_ctrl) begin
			train_en_next = hwdata[LTOVR_TRAIN_EN_BIT];
			lp_ovr_en_next = hwdata[LTOVR_LP_OVR_EN_BIT];
		end
		if (train_en_reg) begin
			coeff_next = lp_coeff_in;
		end else if (wr_coeff) begin
			coeff_next = hwdata[LTOVR_COEFF_W-1:0];
		end
		if (wr_ovr) begin
			ovr_next.max_val = hwdata[LTOVR_MAX_LSB +: 5];
			ovr_next.max_en = hwdata[LTOVR_MAX_EN_BIT];
			ovr_next.min_val = hwdata[LTOVR_MIN_LSB +: 5];
			ovr_next.min_en = hwdata[LTOVR_MIN_EN_BIT];
			ovr_next.post_val = hwdata[LTOVR_POST_LSB +: 6];
			ovr_next.post_en = hwdata[LTOVR_POST_EN_BIT];
		end
		// A new word goes out only once the override is already enabled.
		send_next = wr_next_ctrl && hwdata[LTOVR_NEW_WORD_BIT]
			&& lp_ovr_en_reg;
	end

	// Read mux; every unlisted bit and unmapped address reads zero.
	always_comb begin
		rdata_next = rdata_reg;
		if (addr_phase && !hwrite) begin
			rdata_next = 32'h0000_0000;
			case (haddr[9:0])
				LTOVR_ADDR_TRAIN_CTRL: begin
					rdata_next[LTOVR_TRAIN_EN_BIT] = train_en_next;
					rdata_next[LTOVR_LP_OVR_EN_BIT] = lp_ovr_en_next;
				end
				LTOVR_ADDR_LP_COEFF: begin
					rdata_next[LTOVR_COEFF_W-1:0] = coeff_next;
				end
				LTOVR_ADDR_LIMIT_OVR: begin
					rdata_next[LTOVR_MAX_LSB +: 5] = ovr_next.max_val;
					rdata_next[LTOVR_MAX_EN_BIT] = ovr_next.max_en;
					rdata_next[LTOVR_MIN_LSB +: 5] = ovr_next.min_val;
					rdata_next[LTOVR_MIN_EN_BIT] = ovr_next.min_en;
					rdata_next[LTOVR_POST_LSB +: 6] = ovr_next.post_val;
					rdata_next[LTOVR_POST_EN_BIT] = ovr_next.post_en;
				end
				default: begin
					rdata_next = 32'h0000_0000;
				end
			endcase
		end
	end

	// Per-tap decode; the reserved code acts as hold.
	for (genvar t = 0; t < 3; t++) begin : g_tap
		always_comb begin
			inc_next[t] = coeff_reg[2*t +: 2] == LTOVR_TAP_INC;
			dec_next[t] = coeff_reg[2*t +: 2] == LTOVR_TAP_DEC;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= LTOVR_ST_IDLE;
			wa_reg <= 10'h000;
			train_en_reg <= LTOVR_TRAIN_EN_RST;
			lp_ovr_en_reg <= LTOVR_LP_OVR_EN_RST;
			coeff_reg <= 6'h00;
			ovr_reg <= OVR_RST;
			send_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			inc_reg <= 3'h0;
			dec_reg <= 3'h0;
		end else begin
			st_reg <= st_next;
			wa_reg <= wa_next;
			train_en_reg <= train_en_next;
			lp_ovr_en_reg <= lp_ovr_en_next;
			coeff_reg <= coeff_next;
			ovr_reg <= ovr_next;
			send_reg <= send_next;
			rdata_reg <= rdata_next;
			inc_reg <= inc_next;
			dec_reg <= dec_next;
		end
	end

	ltovr_limit_sel u_limit_sel (
		.hclk(hclk),
		.hresetn(hresetn),
		.ovr(ovr_reg),
		.cfg(cfg_limits),
		.tx_limits(tx_limits)
	);

	assign hreadyout = 1'b1;
	assign hresp = LTOVR_HRESP_OKAY;
	assign hrdata = rdata_reg;
	assign lp_coeff_out = coeff_reg;
	assign tap_inc = inc_reg;
	assign tap_dec = dec_reg;
	assign train_enable = train_en_reg;
	assign lp_coeff_send = send_reg;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_coeff_follow;
		train_en_reg |=> coeff_reg == $past(lp_coeff_in);
	endproperty
	a_coeff_follow: assert property (p_coeff_follow)
		else $error("coefficient bits did not follow training");

	property p_coeff_write;
		(wr_coeff && !train_en_reg) |=> lp_coeff_out == $past(hwdata[5:0]);
	endproperty
	a_coeff_write: assert property (p_coeff_write)
		else $error("coefficient write while training off was lost");

	property p_tap_inc;
		coeff_reg[1:0] == LTOVR_TAP_INC |=> tap_inc[0] && !tap_dec[0];
	endproperty
	a_tap_inc: assert property (p_tap_inc)
		else $error("increment code not decoded");

	property p_tap_rsvd;
		coeff_reg[5:4] == LTOVR_TAP_RSVD |=> !tap_inc[2] && !tap_dec[2];
	endproperty
	a_tap_rsvd: assert property (p_tap_rsvd)
		else $error("reserved code did not act as hold");

	property p_send;
		(wr_next_ctrl && hwdata[LTOVR_NEW_WORD_BIT] && lp_ovr_en_reg)
			|=> lp_coeff_send;
	endproperty
	a_send: assert property (p_send)
		else $error("new word pulse wrong");

	// Back-to-back flagged writes may hold the pulse; anything else drops it.
	property p_no_send;
		!(wr_next_ctrl && hwdata[LTOVR_NEW_WORD_BIT] && lp_ovr_en_reg)
			|=> !lp_coeff_send;
	endproperty
	a_no_send: assert property (p_no_send)
		else $error("new word sent without a flagged write under override");

	property p_max_sel;
		ovr_reg.max_en |=> tx_limits.upper == $past(ovr_reg.max_val)
			&& tx_limits.preset == $past(ovr_reg.max_val);
	endproperty
	a_max_sel: assert property (p_max_sel)
		else $error("max override not applied");

	property p_max_off;
		!ovr_reg.max_en |=> tx_limits.upper == $past(cfg_limits.upper)
			&& tx_limits.preset == $past(cfg_limits.preset);
	endproperty
	a_max_off: assert property (p_max_off)
		else $error("max override applied while disabled");

	property p_min_sel;
		ovr_reg.min_en |=> tx_limits.lower == $past(ovr_reg.min_val);
	endproperty
	a_min_sel: assert property (p_min_sel)
		else $error("min override not applied");

	property p_post_sel;
		ovr_reg.post_en |=> tx_limits.post == $past(ovr_reg.post_val);
	endproperty
	a_post_sel: assert property (p_post_sel)
		else $error("post override not applied");

	property p_rsvd_zero;
		hrdata[31:23] == 9'h000 && hrdata[15:14] == 2'b00
			&& hrdata[7:6] == 2'b00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bits read nonzero");

	c_coeff_write: cover property (wr_coeff && !train_en_reg);
	c_send: cover property (lp_coeff_send);
	c_max_ovr: cover property (ovr_reg.max_en && wr_ovr);
endmodule : ltovr_regs

// ### dv/test_lt_lane0_tx_eq_override_regs.sv
// Self-checking testbench for the lane 0 training override register slice.
`timescale 1ns/100ps
module test_lt_lane0_tx_eq_override_regs;
	import ltovr_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [5:0] lp_coeff_in = 6'h00;
	ltovr_limits_type cfg = '0;
	ltovr_limits_type tx_limits;
	ltovr_limits_type exp_lim;
	logic [31:0] hrdata_hw;
	ltovr_limits_type tx_limits_hw;
	logic [5:0] lp_coeff_out;
	logic [2:0] tap_inc;
	logic [2:0] tap_dec;
	logic [2:0] ei;
	logic [2:0] ed;
	logic train_enable;
	logic lp_coeff_send;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int pulses = 0;
	int p0;
	int seed = 70389;
	logic [31:0] mdl [logic [31:0]];
	logic [31:0] rd;
	logic [31:0] rv;
	logic [5:0] v;

	always #5 hclk = ~hclk;

	ltovr_regs #(.SIM_BUILD(1'b1)) uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.lp_coeff_in(lp_coeff_in), .cfg_limits(cfg), .tx_limits(tx_limits),
		.lp_coeff_out(lp_coeff_out), .tap_inc(tap_inc), .tap_dec(tap_dec),
		.train_enable(train_enable), .lp_coeff_send(lp_coeff_send));

	// A second slice built with the hardware reset values shares the bus.
	ltovr_regs #(.SIM_BUILD(1'b0)) uut_hw (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(), .hresp(), .hrdata(hrdata_hw),
		.lp_coeff_in(lp_coeff_in), .cfg_limits(cfg),
		.tx_limits(tx_limits_hw), .lp_coeff_out(), .tap_inc(), .tap_dec(),
		.train_enable(), .lp_coeff_send());

	task automatic tally_and_finish();
		if (n_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge hclk) begin
		cycles++;
		if (lp_coeff_send === 1'b1) begin
			pulses++;
		end
		if (cycles == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer

	function automatic logic [31:0] wmask(input logic [31:0] a);
		case (a)
			32'h340: return 32'h0002_0001;
			32'h354: return mdl[32'h340][0] ? 32'h0 : 32'h3F;
			32'h358: return 32'h007F_3F3F;
			default: return 32'h0;
		endcase
	endfunction : wmask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] m;
		logic [31:0] old;
		m = wmask(a);
		old = mdl.exists(a) ? mdl[a] : 32'h0;
		xfer(1'b1, a, d, rd);
		mdl[a] = (old & ~m) | (d & m);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a);
		xfer(1'b0, a, 32'h0, rd);
		check(rd, mdl.exists(a) ? mdl[a] : 32'h0);
		check(hresp, LTOVR_HRESP_OKAY);
	endtask : rd_chk

	task automatic lim_chk();
		rv = mdl[32'h358];
		exp_lim.upper = rv[5] ? rv[4:0] : cfg.upper;
		exp_lim.preset = rv[5] ? rv[4:0] : cfg.preset;
		exp_lim.lower = rv[13] ? rv[12:8] : cfg.lower;
		exp_lim.post = rv[22] ? rv[21:16] : cfg.post;
		check({11'h0, tx_limits}, {11'h0, exp_lim});
	endtask : lim_chk

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rv = $random(seed);
		cfg <= rv[20:0];
		mdl[32'h340] = 32'h1;
		mdl[32'h354] = 32'h0;
		mdl[32'h358] = 32'h0046_393C;
		rd_chk(32'h358);
		check(hrdata_hw, 32'h0);
		rd_chk(32'h340);
		lim_chk();
		check({11'h0, tx_limits_hw}, {11'h0, cfg});
		check(train_enable, 1'b1);
		for (int i = 0; i < 8; i++) begin
			rv = $random(seed);
			v = (i < 4) ? {3{i[1:0]}} : rv[5:0];
			@(posedge hclk);
			lp_coeff_in <= v;
			mdl[32'h354] = {26'h0, v};
			repeat (3) @(posedge hclk);
			#1;
			for (int j = 0; j < 3; j++) begin
				ei[j] = (v[2*j+:2] == 2'b01);
				ed[j] = (v[2*j+:2] == 2'b10);
			end
			check(lp_coeff_out, v);
			check({tap_dec, tap_inc}, {ed, ei});
			wr(32'h354, ~rv);
			rd_chk(32'h354);
		end
		wr(32'h340, 32'h0);
		#1;
		check(train_enable, 1'b0);
		rv = $random(seed);
		wr(32'h354, rv);
		lp_coeff_in <= ~rv[5:0];
		rd_chk(32'h354);
		check(lp_coeff_out, rv[5:0]);
		p0 = pulses;
		wr(32'h348, 32'h100);
		repeat (3) @(posedge hclk);
		check(pulses, p0);
		wr(32'h340, 32'h0002_0000);
		wr(32'h348, 32'h100);
		#1;
		check(lp_coeff_send, 1'b1);
		@(posedge hclk);
		#1;
		check(lp_coeff_send, 1'b0);
		check(pulses, p0 + 1);
		rd_chk(32'h348);
		rd_chk(32'h340);
		for (int i = 0; i < 8; i++) begin
			rv = $random(seed);
			cfg <= rv[31:11];
			wr(32'h358, $random(seed));
			repeat (2) @(posedge hclk);
			#1;
			lim_chk();
			rd_chk(32'h358);
		end
		// Overrides kept inside the configured window, as software should.
		cfg <= {5'h1E, 5'h04, 6'h10, 5'h14};
		wr(32'h358, 32'h0052_283C);
		repeat (2) @(posedge hclk);
		#1;
		lim_chk();
		rd_chk(32'h358);
		wr(32'h35C, $random(seed));
		rd_chk(32'h35C);
		rd_chk(32'h3FC);
		tally_and_finish();
	end
endmodule : test_lt_lane0_tx_eq_override_regs
